// ---- rtl/ssc_regs.sv ----
// file: system status and control registers behind an AHB-Lite slave
//
// Overview of operation
// - read-only 12-bit part number split over high [3:0] and low [7:0] registers
// - high ident bits 7:4 reserved, read fixed value, writes ignored
// - wakeup flag bit 7 read-only, set on timer timeout
// - writing 1 to wakeup ack bit 6 clears flag; ack reads 0
// - bit 5 picks internal 1 kHz tick or external clock
// - wakeup interrupt raised only when enable bit 4 and flag both set
// - period code zero disables the wakeup timer
// - internal periods 8 ms up to 1.024 s for codes 1 to 7
// - external periods 256 up to 32768 clocks for codes 1 to 7
// - first timeout may come up to one tick early
// - low-voltage flag set on detect event only while detect enabled
// - writing 1 to low-voltage ack clears flag; ack reads 0
// - low-voltage interrupt requested while enable bit 5 and flag set
// - write-once bit 4 makes set flag force reset, only when detect enabled
// - bit 3 keeps detection running in stop mode, only when detect enabled
// - write-once bit 2 enables detection; zero keeps flag, reset, stop inactive
// - bit 0 drives bandgap buffer enable; bit 1 reserved, written zero
// - write-once bits take the first write after reset only
// - full power-down recovered flag at bit 4, read-only
// - partial power-down recovered flag at bit 3, read-only
// - writing 1 to power-down ack bit 2 clears both recovery flags
// - bit 1 enables power-down stop modes; bit 0 selects partial
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ssc_regs
	import ssc_pkg::*;
#(
	parameter int TICK_CYCLES = SSC_TICK_CYCLES
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        ext_clk_pin,
	input  wire logic        low_voltage_detect_pin,
	input  wire logic        in_stop_mode,
	input  wire logic        full_powerdown_wakeup,
	input  wire logic        partial_powerdown_wakeup,
	output logic             wakeup_irq,
	output logic             low_voltage_irq,
	output logic             low_voltage_reset_req,
	output logic             low_voltage_detect_active,
	output logic             bandgap_buffer_enable,
	output logic             powerdown_modes_enable,
	output logic             partial_powerdown_select
);
	// bus phase capture
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic        ahb_go;
	// wakeup register fields
	logic        wakeup_timeout_flag_reg;
	logic        wakeup_clock_select_reg;
	logic        wakeup_irq_enable_reg;
	logic [2:0]  wakeup_period_select_reg;
	logic        wakeup_timeout;
	// low-voltage register fields
	logic        low_voltage_flag_reg;
	logic        low_voltage_irq_enable_reg;
	logic        low_voltage_reset_enable_reg;
	logic        low_voltage_stop_enable_reg;
	logic        low_voltage_detect_enable_reg;
	logic        bandgap_buffer_enable_reg;
	logic        lv_reserved_reg;
	logic        lv_once_done_reg;
	logic        lv_event;
	logic [2:0]  lv_sync_reg;
	logic        lv_level_reg;
	// power-down register fields
	logic        full_powerdown_recovered_reg;
	logic        partial_powerdown_recovered_reg;
	logic        powerdown_modes_enable_reg;
	logic        partial_powerdown_select_reg;
	logic        pd_full_sync_reg;
	logic        pd_part_sync_reg;
	// write strobes
	logic        wr_wakeup;
	logic        wr_lowvolt;
	logic        wr_powerdown;
	logic [7:0]  wd;

	// true when the address names a word register of this block
	function automatic logic ssc_hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	assign ahb_go    = hsel && hready && htrans[1];
	assign hreadyout = 1'b1; // zero wait states, every access answers at once
	assign hresp     = 1'b0;
	assign wd        = hwdata[7:0];

	// write address phase held for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h0;
		end else begin
			wr_pend_reg <= ahb_go && hwrite;
			if (ahb_go)
				wr_addr_reg <= haddr[7:0];
		end
	end

	assign wr_wakeup    = wr_pend_reg && ssc_hit(wr_addr_reg, SSC_OFS_WAKEUP);
	assign wr_lowvolt   = wr_pend_reg && ssc_hit(wr_addr_reg, SSC_OFS_LOWVOLT);
	assign wr_powerdown = wr_pend_reg && ssc_hit(wr_addr_reg, SSC_OFS_POWERDOWN);

	// read data registered at the address phase; unmapped reads give zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (ahb_go && !hwrite) begin
			if (ssc_hit(haddr[7:0], SSC_OFS_IDENT_HIGH))
				hrdata <= {24'h0, SSC_IDENT_RSVD, SSC_PART_NUMBER[11:8]};
			else if (ssc_hit(haddr[7:0], SSC_OFS_IDENT_LOW))
				hrdata <= {24'h0, SSC_PART_NUMBER[7:0]};
			else if (ssc_hit(haddr[7:0], SSC_OFS_WAKEUP))
				hrdata <= {24'h0, wakeup_timeout_flag_reg, 1'b0, wakeup_clock_select_reg,
					wakeup_irq_enable_reg, 1'b0, wakeup_period_select_reg};
			else if (ssc_hit(haddr[7:0], SSC_OFS_LOWVOLT))
				hrdata <= {24'h0, low_voltage_flag_reg, 1'b0, low_voltage_irq_enable_reg,
					low_voltage_reset_enable_reg, low_voltage_stop_enable_reg,
					low_voltage_detect_enable_reg, lv_reserved_reg,
					bandgap_buffer_enable_reg};
			else if (ssc_hit(haddr[7:0], SSC_OFS_POWERDOWN))
				hrdata <= {27'h0, full_powerdown_recovered_reg, partial_powerdown_recovered_reg,
					1'b0, powerdown_modes_enable_reg, partial_powerdown_select_reg};
			else
				hrdata <= 32'h0;
		end
	end

	// wakeup timer engine
	ssc_wakeup_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.hclk          (hclk),
		.hresetn       (hresetn),
		.clk_select    (wakeup_clock_select_reg),
		.period_select (wakeup_period_select_reg),
		.ext_clk_pin   (ext_clk_pin),
		.timeout       (wakeup_timeout)
	);

	// wakeup control fields
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wakeup_clock_select_reg  <= 1'b0;
			wakeup_irq_enable_reg    <= 1'b0;
			wakeup_period_select_reg <= SSC_PERIOD_RESET;
		end else if (wr_wakeup) begin
			wakeup_clock_select_reg  <= wd[SSC_WK_CLKS_BIT];
			wakeup_irq_enable_reg    <= wd[SSC_WK_IE_BIT];
			wakeup_period_select_reg <= wd[2:0];
		end
	end

	// wakeup flag; timeout outranks a same-cycle acknowledge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wakeup_timeout_flag_reg <= 1'b0;
		else if (wakeup_timeout)
			wakeup_timeout_flag_reg <= 1'b1;
		else if (wr_wakeup && wd[SSC_WK_ACK_BIT])
			wakeup_timeout_flag_reg <= 1'b0;
	end

	assign wakeup_irq = wakeup_irq_enable_reg && wakeup_timeout_flag_reg;

	// detector output from the analog side, filtered like any pin
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lv_sync_reg  <= 3'h0;
			lv_level_reg <= 1'b0;
		end else begin
			lv_sync_reg <= {lv_sync_reg[1:0], low_voltage_detect_pin};
			if (lv_sync_reg[1] == lv_sync_reg[2])
				lv_level_reg <= lv_sync_reg[2];
		end
	end

	// in stop mode detection runs only with the stop enable set
	assign low_voltage_detect_active = low_voltage_detect_enable_reg &&
		(!in_stop_mode || low_voltage_stop_enable_reg);
	assign lv_event = lv_level_reg && low_voltage_detect_active;

	// low-voltage plain control bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_voltage_irq_enable_reg  <= 1'b0;
			low_voltage_stop_enable_reg <= 1'b0;
			bandgap_buffer_enable_reg   <= 1'b0;
			lv_reserved_reg             <= 1'b0;
		end else if (wr_lowvolt) begin
			low_voltage_irq_enable_reg  <= wd[SSC_LV_IE_BIT];
			low_voltage_stop_enable_reg <= wd[SSC_LV_SE_BIT];
			bandgap_buffer_enable_reg   <= wd[SSC_LV_BANDGAP_BUFFER_ENABLE_BIT];
			lv_reserved_reg             <= wd[1];
		end
	end

	// write-once bits: the first write after reset locks them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_voltage_reset_enable_reg  <= 1'b0;
			low_voltage_detect_enable_reg <= 1'b0;
			lv_once_done_reg              <= 1'b0;
		end else if (wr_lowvolt && !lv_once_done_reg) begin
			low_voltage_reset_enable_reg  <= wd[SSC_LV_RE_BIT];
			low_voltage_detect_enable_reg <= wd[SSC_LV_DE_BIT];
			lv_once_done_reg              <= 1'b1;
		end
	end

	// low-voltage flag; a live detect outranks the acknowledge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			low_voltage_flag_reg <= 1'b0;
		else if (lv_event)
			low_voltage_flag_reg <= 1'b1;
		else if (wr_lowvolt && wd[SSC_LV_ACK_BIT])
			low_voltage_flag_reg <= 1'b0;
	end

	assign low_voltage_irq = low_voltage_irq_enable_reg && low_voltage_flag_reg;
	assign low_voltage_reset_req = low_voltage_reset_enable_reg &&
		low_voltage_detect_enable_reg && low_voltage_flag_reg;
	assign bandgap_buffer_enable = bandgap_buffer_enable_reg;

	// recovery strobes come from the power controller on this clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pd_full_sync_reg <= 1'b0;
			pd_part_sync_reg <= 1'b0;
		end else begin
			pd_full_sync_reg <= full_powerdown_wakeup;
			pd_part_sync_reg <= partial_powerdown_wakeup;
		end
	end

	// recovery flags; a recovery outranks the acknowledge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			full_powerdown_recovered_reg    <= 1'b0;
			partial_powerdown_recovered_reg <= 1'b0;
		end else begin
			if (pd_full_sync_reg)
				full_powerdown_recovered_reg <= 1'b1;
			else if (wr_powerdown && wd[SSC_PD_ACK_BIT])
				full_powerdown_recovered_reg <= 1'b0;
			if (pd_part_sync_reg)
				partial_powerdown_recovered_reg <= 1'b1;
			else if (wr_powerdown && wd[SSC_PD_ACK_BIT])
				partial_powerdown_recovered_reg <= 1'b0;
		end
	end

	// stop mode controls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			powerdown_modes_enable_reg   <= 1'b0;
			partial_powerdown_select_reg <= 1'b0;
		end else if (wr_powerdown) begin
			powerdown_modes_enable_reg   <= wd[SSC_PD_EN_BIT];
			partial_powerdown_select_reg <= wd[SSC_PD_SEL_BIT];
		end
	end
	assign powerdown_modes_enable   = powerdown_modes_enable_reg;
	assign partial_powerdown_select = partial_powerdown_select_reg;

	// flags, acknowledges and locks, checked on the registers this block drives
	wk_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wakeup_timeout |=> wakeup_timeout_flag_reg)
		else $error("wakeup flag not set");
	wk_ack_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_wakeup && wd[SSC_WK_ACK_BIT] && !wakeup_timeout) |=> !wakeup_timeout_flag_reg)
		else $error("wakeup ack failed");
	wk_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(wakeup_irq) |-> $past(wakeup_timeout) || $past(wr_wakeup))
		else $error("wakeup irq raised without timeout or enable write");
	lv_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(!low_voltage_detect_enable_reg && !low_voltage_flag_reg) |=> !low_voltage_flag_reg)
		else $error("lv flag set while detection off");
	lv_ack_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_lowvolt && wd[SSC_LV_ACK_BIT] && !lv_event) |=> !low_voltage_flag_reg)
		else $error("lv ack failed");
	lv_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
		low_voltage_reset_req |-> low_voltage_detect_enable_reg && low_voltage_flag_reg)
		else $error("lv reset without cause");
	once_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
		lv_once_done_reg |=> $stable(low_voltage_detect_enable_reg))
		else $error("write-once bit changed");
	pd_ack_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_powerdown && wd[SSC_PD_ACK_BIT] && !pd_full_sync_reg && !pd_part_sync_reg)
		|=> !full_powerdown_recovered_reg && !partial_powerdown_recovered_reg)
		else $error("power-down ack failed");
	set_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(wakeup_timeout && wr_wakeup) |=> wakeup_timeout_flag_reg)
		else $error("set lost to ack");

	// set paths, second lock bit, read-back and plain control writes
	lv_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		lv_event |=> low_voltage_flag_reg)
		else $error("lv flag not set");
	lv_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(low_voltage_irq) |-> $past(lv_event) || $past(wr_lowvolt))
		else $error("lv irq raised without event or enable write");
	stop_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(in_stop_mode && !low_voltage_stop_enable_reg && !low_voltage_flag_reg)
		|=> !low_voltage_flag_reg)
		else $error("lv flag set in stop without stop enable");
	re_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
		lv_once_done_reg |=> $stable(low_voltage_reset_enable_reg))
		else $error("reset enable changed after lock");
	pd_full_a: assert property (@(posedge hclk) disable iff (!hresetn)
		pd_full_sync_reg |=> full_powerdown_recovered_reg)
		else $error("full recovery flag not set");
	pd_part_a: assert property (@(posedge hclk) disable iff (!hresetn)
		pd_part_sync_reg |=> partial_powerdown_recovered_reg)
		else $error("partial recovery flag not set");
	ident_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ahb_go && !hwrite && ssc_hit(haddr[7:0], SSC_OFS_IDENT_HIGH))
		|=> hrdata == {24'h0, SSC_IDENT_RSVD, SSC_PART_NUMBER[11:8]})
		else $error("ident high read wrong");
	bg_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_lowvolt |=> bandgap_buffer_enable == $past(wd[SSC_LV_BANDGAP_BUFFER_ENABLE_BIT]))
		else $error("bandgap enable not written");
	pd_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_powerdown |=> powerdown_modes_enable == $past(wd[SSC_PD_EN_BIT]))
		else $error("power-down enable not written");

	// main scenarios the bench is expected to reach
	wk_irq_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(wakeup_irq));
	lv_flag_c: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(low_voltage_flag_reg));
	set_ack_c: cover property (@(posedge hclk) disable iff (!hresetn)
		wakeup_timeout && wr_wakeup);
	lv_rst_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(low_voltage_reset_req));
	pd_ack_c: cover property (@(posedge hclk) disable iff (!hresetn)
		full_powerdown_recovered_reg ##1 !full_powerdown_recovered_reg);
endmodule

// ---- rtl/ssc_pkg.sv ----
// package: register map, field positions, reset values and timing for the system status block
package ssc_pkg;
	// byte offsets on the 32-bit bus, one register per word
	localparam logic [7:0] SSC_OFS_IDENT_HIGH = 8'h00;
	localparam logic [7:0] SSC_OFS_IDENT_LOW  = 8'h04;
	localparam logic [7:0] SSC_OFS_WAKEUP     = 8'h08;
	localparam logic [7:0] SSC_OFS_LOWVOLT    = 8'h0C;
	localparam logic [7:0] SSC_OFS_POWERDOWN  = 8'h10;
	// wakeup_timer_status_ctrl fields
	localparam int SSC_WK_FLAG_BIT  = 7;
	localparam int SSC_WK_ACK_BIT   = 6;
	localparam int SSC_WK_CLKS_BIT  = 5;
	localparam int SSC_WK_IE_BIT    = 4;
	// low_voltage_status_ctrl fields
	localparam int SSC_LV_FLAG_BIT  = 7;
	localparam int SSC_LV_ACK_BIT   = 6;
	localparam int SSC_LV_IE_BIT    = 5;
	localparam int SSC_LV_RE_BIT    = 4;
	localparam int SSC_LV_SE_BIT    = 3;
	localparam int SSC_LV_DE_BIT    = 2;
	localparam int SSC_LV_BANDGAP_BUFFER_ENABLE_BIT  = 0;
	// power_down_status_ctrl fields
	localparam int SSC_PD_FULL_BIT  = 4;
	localparam int SSC_PD_PART_BIT  = 3;
	localparam int SSC_PD_ACK_BIT   = 2;
	localparam int SSC_PD_EN_BIT    = 1;
	localparam int SSC_PD_SEL_BIT   = 0;
	// reset values of the control fields
	localparam logic [2:0] SSC_PERIOD_RESET = 3'h0;
	// timing: bus clock and internal wakeup tick
	localparam int SSC_CLK_HZ        = 50000000;
	localparam int SSC_TICK_PERIOD_US = 1000;
	localparam int SSC_TICK_CYCLES   = SSC_CLK_HZ / 1000000 * SSC_TICK_PERIOD_US;
	// undefined value returned by the reserved ident bits
	localparam logic [3:0] SSC_IDENT_RSVD = 4'h0;
	// neutral part number, value arbitrary
	localparam logic [11:0] SSC_PART_NUMBER = 12'h5A3;
endpackage

// ---- rtl/ssc_wakeup_timer.sv ----
// file: periodic wakeup timer counting internal ticks or external clock edges
`timescale 1ns/1ps
module ssc_wakeup_timer
	import ssc_pkg::*;
#(
	parameter int TICK_CYCLES = SSC_TICK_CYCLES
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       clk_select,
	input  wire logic [2:0] period_select,
	input  wire logic       ext_clk_pin,
	output logic            timeout
);
	logic [2:0]  ext_sync_reg;
	logic        ext_level_reg;
	logic [31:0] tick_cnt_reg;
	logic [15:0] count_reg;
	logic [15:0] limit;
	logic        int_tick;
	logic        ext_edge;
	logic        step;

	// three stages; a rise to high counts once stages two and three agree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_sync_reg  <= 3'h0;
			ext_level_reg <= 1'b0;
		end else begin
			ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_pin};
			if (ext_sync_reg[1] == ext_sync_reg[2])
				ext_level_reg <= ext_sync_reg[2];
		end
	end
	assign ext_edge = (ext_sync_reg[1] == ext_sync_reg[2]) && ext_sync_reg[2] && !ext_level_reg;

	// 1 ms prescaler runs free, so the first timeout may be up to one tick short
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tick_cnt_reg <= 32'h0;
		else if (tick_cnt_reg == 32'(TICK_CYCLES - 1))
			tick_cnt_reg <= 32'h0;
		else
			tick_cnt_reg <= tick_cnt_reg + 32'h1;
	end
	assign int_tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

	// period table for each source
	always_comb begin
		limit = 16'h0;
		case (period_select)
			3'h1: limit = clk_select ? 16'h00FF : 16'h0007;
			3'h2: limit = clk_select ? 16'h03FF : 16'h001F;
			3'h3: limit = clk_select ? 16'h07FF : 16'h003F;
			3'h4: limit = clk_select ? 16'h0FFF : 16'h007F;
			3'h5: limit = clk_select ? 16'h1FFF : 16'h00FF;
			3'h6: limit = clk_select ? 16'h3FFF : 16'h01FF;
			3'h7: limit = clk_select ? 16'h7FFF : 16'h03FF;
			default: limit = 16'h0;
		endcase
	end
	assign step = clk_select ? ext_edge : int_tick;

	// period counter; code zero holds it cleared and stops timeouts
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= 16'h0;
			timeout   <= 1'b0;
		end else begin
			timeout <= 1'b0;
			if (period_select == 3'h0) begin
				count_reg <= 16'h0;
			end else if (step) begin
				if (count_reg >= limit) begin
					count_reg <= 16'h0;
					timeout   <= 1'b1;
				end else begin
					count_reg <= count_reg + 16'h1;
				end
			end
		end
	end

	disabled_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(period_select == 3'h0) |=> !timeout)
		else $error("timeout while timer disabled");
endmodule

// ---- verif/tb_system_status_control_regs.sv ----
// testbench: register access, wakeup timer, low-voltage and power-down behaviour
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_system_status_control_regs;
	import ssc_pkg::*;
	localparam int TICK = 4; // short prescaler keeps the longest period simulable
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic        hready;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        ext_clk_pin;
	logic        lv_pin;
	logic        in_stop_mode;
	logic        full_wake;
	logic        part_wake;
	logic        ext_run;
	logic        wakeup_irq;
	logic        lv_irq;
	logic        lv_rst;
	logic        lv_act;
	logic        bg_en;
	logic        pd_en;
	logic        pd_sel;
	int          n_mismatch;
	int          checks_done;
	int          cyc;
	int          ext_edges;
	int          t0;
	int          t1;
	int          n;
	int          per;

	// single slave, so its own ready is the bus ready
	assign hready = hreadyout;

	ssc_regs #(.TICK_CYCLES(TICK)) u_ssc_regs (
		.hclk                     (hclk),
		.hresetn                  (hresetn),
		.hsel                     (hsel),
		.haddr                    (haddr),
		.htrans                   (htrans),
		.hwrite                   (hwrite),
		.hsize                    (hsize),
		.hwdata                   (hwdata),
		.hready                   (hready),
		.hrdata                   (hrdata),
		.hreadyout                (hreadyout),
		.hresp                    (hresp),
		.ext_clk_pin              (ext_clk_pin),
		.low_voltage_detect_pin   (lv_pin),
		.in_stop_mode             (in_stop_mode),
		.full_powerdown_wakeup    (full_wake),
		.partial_powerdown_wakeup (part_wake),
		.wakeup_irq               (wakeup_irq),
		.low_voltage_irq          (lv_irq),
		.low_voltage_reset_req    (lv_rst),
		.low_voltage_detect_active(lv_act),
		.bandgap_buffer_enable    (bg_en),
		.powerdown_modes_enable   (pd_en),
		.partial_powerdown_select (pd_sel)
	);

	// bus clock, 20 ns period
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	// cycle count, hang guard and an external wakeup clock of four bus cycles
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (ext_run && cyc[0]) begin
			ext_clk_pin <= ~ext_clk_pin;
			if (!ext_clk_pin)
				ext_edges <= ext_edges + 1;
		end
		if (cyc == 40000) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one single-word transfer; entered and left just after a rising edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] wd);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		hwrite <= w;
		hsize  <= 3'h2;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, d);
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 8'h00);
		`CHK(nm, e, rd)
	endtask

	task automatic do_reset();
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask

	// detector output high long enough to pass the input filter
	task automatic pulse_lv();
		lv_pin <= 1'b1;
		repeat (6) @(posedge hclk);
		lv_pin <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask

	task automatic wake(input logic full);
		full_wake <= full;
		part_wake <= ~full;
		@(posedge hclk);
		{full_wake, part_wake} <= 2'h0;
		repeat (3) @(posedge hclk);
	endtask

	// edge-sampled wait, so rise times compare exactly between calls
	task automatic wait_wk(input int lim);
		n = 0;
		while (wakeup_irq !== 1'b1 && n < lim) begin
			@(posedge hclk);
			n++;
		end
	endtask

	initial begin
		{hsel, hwrite, ext_clk_pin, lv_pin, in_stop_mode, full_wake, part_wake} = 7'h00;
		{haddr, hwdata, htrans, hsize, ext_run, hresetn} = '0;
		{n_mismatch, checks_done, cyc, ext_edges} = '0;
		do_reset();
		`CHK("outs", 7'h00, {wakeup_irq, lv_irq, lv_rst, lv_act, bg_en, pd_en, pd_sel})
		`CHK("hresp", 1'b0, hresp)
		`CHK("hready", 1'b1, hreadyout)
		rchk("wk_rst", SSC_OFS_WAKEUP, 32'h0);
		rchk("pd_rst", SSC_OFS_POWERDOWN, 32'h0);
		wr(SSC_OFS_IDENT_HIGH, 8'hFF);
		wr(SSC_OFS_IDENT_LOW, 8'h00);
		rchk("idh", SSC_OFS_IDENT_HIGH, {24'h0, SSC_IDENT_RSVD, SSC_PART_NUMBER[11:8]});
		rchk("idl", SSC_OFS_IDENT_LOW, {24'h0, SSC_PART_NUMBER[7:0]});
		wr(8'h40, 8'hFF);
		rchk("unmapped", 8'h40, 32'h0);
		// detect left off by the first write, then locked there
		wr(SSC_OFS_LOWVOLT, 8'h30);
		wr(SSC_OFS_LOWVOLT, 8'h24);
		rchk("lv_lock", SSC_OFS_LOWVOLT, 32'h30);
		pulse_lv();
		rchk("lv_off", SSC_OFS_LOWVOLT, 32'h30);
		`CHK("lv_outs", 3'h0, {lv_irq, lv_rst, lv_act})
		$display("test ident_and_detect_off done");
		// second reset clears the write-once lock
		do_reset();
		rchk("lv_rst", SSC_OFS_LOWVOLT, 32'h0);
		wr(SSC_OFS_LOWVOLT, 8'h35);
		wr(SSC_OFS_LOWVOLT, 8'h00);
		rchk("lv_once", SSC_OFS_LOWVOLT, 32'h14);
		`CHK("bg_off", 1'b0, bg_en)
		wr(SSC_OFS_LOWVOLT, 8'h21);
		@(posedge hclk);
		`CHK("lv_on", 2'h3, {lv_act, bg_en})
		pulse_lv();
		rchk("lv_flag", SSC_OFS_LOWVOLT, 32'hB5);
		`CHK("lv_irq_rst", 2'h3, {lv_irq, lv_rst})
		wr(SSC_OFS_LOWVOLT, 8'h15);
		@(posedge hclk);
		`CHK("lv_poll", 2'h1, {lv_irq, lv_rst})
		wr(SSC_OFS_LOWVOLT, 8'h55);
		rchk("lv_ack", SSC_OFS_LOWVOLT, 32'h15);
		`CHK("lv_rst_off", 1'b0, lv_rst)
		in_stop_mode <= 1'b1;
		pulse_lv();
		rchk("lv_stop_off", SSC_OFS_LOWVOLT, 32'h15);
		wr(SSC_OFS_LOWVOLT, 8'h1D);
		pulse_lv();
		rchk("lv_stop_on", SSC_OFS_LOWVOLT, 32'h9D);
		in_stop_mode <= 1'b0;
		wr(SSC_OFS_LOWVOLT, 8'h5D);
		// reset enable left clear: a set flag alone must not ask for a reset
		do_reset();
		wr(SSC_OFS_LOWVOLT, 8'h24);
		pulse_lv();
		`CHK("lv_no_rst", 2'h2, {lv_irq, lv_rst})
		$display("test low_voltage done");
		wr(SSC_OFS_POWERDOWN, 8'h03);
		@(posedge hclk);
		`CHK("pd_outs", 2'h3, {pd_en, pd_sel})
		wr(SSC_OFS_POWERDOWN, 8'h02);
		wake(1'b1);
		rchk("pd_full", SSC_OFS_POWERDOWN, 32'h12);
		`CHK("pd_stop1", 2'h2, {pd_en, pd_sel})
		wake(1'b0);
		rchk("pd_part", SSC_OFS_POWERDOWN, 32'h1A);
		wr(SSC_OFS_POWERDOWN, 8'h06);
		rchk("pd_ack", SSC_OFS_POWERDOWN, 32'h02);
		$display("test power_down done");
		// external source with period zero must stay silent
		wr(SSC_OFS_WAKEUP, 8'h70);
		rchk("wk_rw", SSC_OFS_WAKEUP, 32'h30);
		ext_run <= 1'b1;
		repeat (1200) @(posedge hclk);
		rchk("wk_off", SSC_OFS_WAKEUP, 32'h30);
		wr(SSC_OFS_WAKEUP, 8'h31);
		t0 = ext_edges;
		wait_wk(1400);
		t1 = ext_edges - t0;
		`CHK("wk_ext", 1'b1, (t1 >= 255 && t1 <= 258))
		ext_run <= 1'b0;
		wr(SSC_OFS_WAKEUP, 8'h40);
		rchk("wk_ack0", SSC_OFS_WAKEUP, 32'h0);
		// flag without enable: visible in the register, no request
		wr(SSC_OFS_WAKEUP, 8'h01);
		repeat (40) @(posedge hclk);
		rchk("wk_mask", SSC_OFS_WAKEUP, 32'h81);
		`CHK("wk_irq_off", 1'b0, wakeup_irq)
		wr(SSC_OFS_WAKEUP, 8'h40);
		for (int c = 1; c < 8; c++) begin
			per = (c == 1) ? 8 : (8 << c);
			wr(SSC_OFS_WAKEUP, 8'h10 | 8'(c));
			t0 = cyc;
			wait_wk(per * TICK + 10);
			t1 = cyc;
			`CHK("wk_first", 1'b1, (t1 - t0 >= (per - 1) * TICK && t1 - t0 <= per * TICK + 4))
			wr(SSC_OFS_WAKEUP, 8'h50 | 8'(c));
			@(posedge hclk);
			`CHK("wk_ack", 1'b0, wakeup_irq)
			wait_wk(per * TICK + 10);
			`CHK("wk_next", per * TICK, cyc - t1)
			if (c == 1) begin
				// ack landing on the next timeout edge: the set must win
				repeat (per * TICK - 3) @(posedge hclk);
				wr(SSC_OFS_WAKEUP, 8'h50 | 8'(c));
				@(posedge hclk);
				`CHK("wk_set_wins", 1'b1, wakeup_irq)
			end
			wr(SSC_OFS_WAKEUP, 8'h40);
		end
		$display("test wakeup_timer done");
		close_out();
	end
endmodule
